// ===== eel_pkg.sv
// shared constants for the edge/event line controller
// assumes a 32-bit apb slave port and one 100 MHz core clock
package eel_pkg;

  // *****************************************
  // line counts and widths
  // *****************************************
  localparam int EEL_LINES = 24;
  localparam int EEL_EXT_LINES = 16;
  localparam int EEL_INT_LINES = 8;
  localparam int EEL_PINS = 55;
  localparam int EEL_SEL_W = 6;
  localparam int EEL_AW = 8;

  // *****************************************
  // register byte offsets
  // *****************************************
  localparam logic [7:0] EEL_OFS_RISE = 8'h00;
  localparam logic [7:0] EEL_OFS_FALL = 8'h04;
  localparam logic [7:0] EEL_OFS_IMASK = 8'h08;
  localparam logic [7:0] EEL_OFS_EMASK = 8'h0C;
  localparam logic [7:0] EEL_OFS_PEND = 8'h10;
  localparam logic [7:0] EEL_OFS_SWTRIG = 8'h14;
  localparam logic [7:0] EEL_OFS_LEVEL = 8'h18;
  localparam logic [7:0] EEL_OFS_SEL = 8'h20;
  localparam logic [7:0] EEL_OFS_SEL_LAST = 8'h5C;

  // *****************************************
  // reset values
  // *****************************************
  localparam logic [23:0] EEL_RST_LINES = 24'h000000;
  localparam logic [5:0] EEL_RST_SEL = 6'h00;
  localparam logic [31:0] EEL_RST_RDATA = 32'h00000000;

  // *****************************************
  // edge catcher handshake states
  // *****************************************
  typedef enum logic [0:0] {
    EEL_CATCH_IDLE = 1'b0,
    EEL_CATCH_CLEAR = 1'b1
  } eel_catch_state_t;

endpackage

// ===== eel_edge_catch.sv
// one external line: asynchronous rising and falling edge catchers
// assumes line_pin is a raw pin level, unrelated to core_clk
`timescale 1ns/1ns
`default_nettype none

module eel_edge_catch
  import eel_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // raw line
  input wire logic line_pin,
  // edge selection
  input wire logic rise_en,
  input wire logic fall_en,
  // results
  output logic rise_hit,
  output logic fall_hit,
  output logic line_level,
  output logic caught_any
);

  // *****************************************
  // asynchronous catch
  // *****************************************
  logic caught_rise;
  logic caught_fall;
  logic [1:0] caught;
  logic [1:0] clr;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] en;
  logic [1:0] hit;
  logic lvl1;
  eel_catch_state_t phase [0:1];

  assign en = {fall_en, rise_en};
  assign clr[0] = (phase[0] == EEL_CATCH_CLEAR);
  assign clr[1] = (phase[1] == EEL_CATCH_CLEAR);
  // each catch flop is its own variable, one process apiece
  assign caught = {caught_fall, caught_rise};

  // the pin itself clocks the catcher, so pulses under 10 ns are kept
  always_ff @(posedge line_pin or posedge clr[0]) begin
    if (clr[0]) caught_rise <= 1'b0;
    else caught_rise <= 1'b1;
  end

  always_ff @(negedge line_pin or posedge clr[1]) begin
    if (clr[1]) caught_fall <= 1'b0;
    else caught_fall <= 1'b1;
  end

  // clockless view for stop-mode wake-up
  assign caught_any = |(caught & en);

  // *****************************************
  // synchronise and acknowledge
  // *****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      lvl1 <= 1'b0;
      line_level <= 1'b0;
    end else begin
      sync1 <= caught;
      sync2 <= sync1;
      lvl1 <= line_pin;
      line_level <= lvl1;
    end
  end

  // clear stays up until the catch is seen gone; edges in that window are lost
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (sys_rst) begin
        phase[k] <= EEL_CATCH_CLEAR;
        hit[k] <= 1'b0;
      end else begin
        unique case (phase[k])
          EEL_CATCH_IDLE: begin
            hit[k] <= sync2[k] & en[k];
            if (sync2[k]) phase[k] <= EEL_CATCH_CLEAR;
          end
          EEL_CATCH_CLEAR: begin
            hit[k] <= 1'b0;
            if (!sync2[k]) phase[k] <= EEL_CATCH_IDLE;
          end
        endcase
      end
    end
  end

  assign rise_hit = hit[0];
  assign fall_hit = hit[1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_catch_once: assert property (rise_hit |=> !rise_hit [*3])
    else $error("rising catch reported twice without clearing");

endmodule // eel_edge_catch

`default_nettype wire

// ===== eel_ctrl.sv
// edge/event line controller: 24 lines, edge select, masks, pending,
// irq/event/wake-up requests toward the vectored_irq_controller
// assumes apb master on core_clk and raw gpio pins from the pads
// How it works
// - there are 24 lines, each able to raise an interrupt or an event request.
// - an unmasked line that sees its chosen edge raises a wake-up request.
// - each line picks rising edges, falling edges or both.
// - each line has its own masks, and a masked line sends nothing on.
// - every detected edge sets that line's pending bit, readable by software.
// - external edges are caught by the pin itself, so sub-cycle pulses count.
// - lines 0 to 15 are external, each fed by any of 55 pins through a selector.
// - an active unmasked external line (0 to 15) wakes the chip from stop, even without a clock.
// - lines 16 to 23 come from internal sources such as the voltage detector.
`timescale 1ns/1ns
`default_nettype none

module eel_ctrl
  import eel_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads
  input wire logic [54:0] gpio_pin,
  // internal sources, same clock
  input wire logic supply_voltage_detector_out,
  input wire logic rtc_alarm,
  input wire logic rtc_tamper,
  input wire logic i2c_wake,
  input wire logic usart_wake,
  input wire logic comparator1_out,
  input wire logic comparator2_out,
  input wire logic consumer_control_wake,
  // toward vectored_irq_controller and power control
  output logic [23:0] line_irq,
  output logic [23:0] line_event,
  output logic irq,
  output logic wake_req
);

  // *****************************************
  // declarations
  // *****************************************
  logic [23:0] rise_en;
  logic [23:0] fall_en;
  logic [23:0] irq_mask;
  logic [23:0] evt_mask;
  logic [23:0] pending;
  logic [23:0] next_pending;
  logic [23:0] line_hit;
  logic [23:0] sw_trig;
  logic [23:0] pend_clr;
  logic [5:0] pin_sel [0:15];
  logic [15:0] ext_raw;
  logic [15:0] ext_rise;
  logic [15:0] ext_fall;
  logic [15:0] ext_level;
  logic [15:0] ext_caught;
  logic [7:0] int_cur;
  logic [7:0] int_prev;
  logic [7:0] int_hit;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic wake_q;
  logic stop_wake;
  logic [31:0] read_word;

  // *****************************************
  // helper functions
  // *****************************************

  // pick one pad; codes past the last pad give a quiet line
  function automatic logic eel_pin_pick(input logic [54:0] pins,
                                        input logic [5:0] sel);
    logic v;
    v = 1'b0;
    if (sel < 6'(EEL_PINS)) v = pins[sel];
    return v;
  endfunction

  // word-aligned and inside the map
  function automatic logic eel_addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0) begin
      if (a <= EEL_OFS_LEVEL) ok = 1'b1;
      if (a >= EEL_OFS_SEL && a <= EEL_OFS_SEL_LAST) ok = 1'b1;
    end
    return ok;
  endfunction

  // index of a pin selector from its byte address
  function automatic logic [3:0] eel_sel_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - EEL_OFS_SEL;
    return d[5:2];
  endfunction

  // *****************************************
  // apb decode
  // *****************************************

  // zero wait states: read data is loaded during the setup cycle
  assign pready = 1'b1;
  assign rd_setup = psel & ~penable;
  assign addr_ok = eel_addr_ok(paddr);
  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign pslverr = psel & penable & ~addr_ok;

  // *****************************************
  // configuration registers
  // *****************************************

  // edge selects, masks and pin selectors
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rise_en <= EEL_RST_LINES;
      fall_en <= EEL_RST_LINES;
      irq_mask <= EEL_RST_LINES;
      evt_mask <= EEL_RST_LINES;
      for (int i = 0; i < EEL_EXT_LINES; i++) begin
        pin_sel[i] <= EEL_RST_SEL;
      end
    end else if (wr_acc) begin
      case (paddr)
        EEL_OFS_RISE: rise_en <= pwdata[23:0];
        EEL_OFS_FALL: fall_en <= pwdata[23:0];
        EEL_OFS_IMASK: irq_mask <= pwdata[23:0];
        EEL_OFS_EMASK: evt_mask <= pwdata[23:0];
        default: begin
          if (paddr >= EEL_OFS_SEL) begin
            pin_sel[eel_sel_idx(paddr)] <= pwdata[5:0];
          end
        end
      endcase
    end
  end

  // *****************************************
  // external lines
  // *****************************************

  // selector mux sits ahead of the catchers; a reselect can fake an edge
  for (genvar g = 0; g < EEL_EXT_LINES; g++) begin : g_ext
    assign ext_raw[g] = eel_pin_pick(gpio_pin, pin_sel[g]);

    eel_edge_catch u_catch (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .line_pin(ext_raw[g]),
      .rise_en(rise_en[g]),
      .fall_en(fall_en[g]),
      .rise_hit(ext_rise[g]),
      .fall_hit(ext_fall[g]),
      .line_level(ext_level[g]),
      .caught_any(ext_caught[g])
    );
  end

  // *****************************************
  // internal lines
  // *****************************************

  // internal sources share core_clk, so a plain sample is enough
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_cur <= 8'h00;
      int_prev <= 8'h00;
    end else begin
      int_cur <= {consumer_control_wake, comparator2_out, comparator1_out,
                  usart_wake, i2c_wake, rtc_tamper, rtc_alarm,
                  supply_voltage_detector_out};
      int_prev <= int_cur;
    end
  end

  // edge select on the sampled internal levels
  assign int_hit = (int_cur & ~int_prev & rise_en[23:16]) |
                   (~int_cur & int_prev & fall_en[23:16]);

  // all 24 detectors in one vector
  assign line_hit = {int_hit, ext_rise | ext_fall};

  // *****************************************
  // pending status
  // *****************************************

  // write-one-to-clear and software trigger strobes
  assign pend_clr = (wr_acc && paddr == EEL_OFS_PEND) ? pwdata[23:0] : 24'h000000;
  assign sw_trig = (wr_acc && paddr == EEL_OFS_SWTRIG) ? pwdata[23:0] : 24'h000000;

  // a hit in the clearing cycle wins, so no edge is dropped
  assign next_pending = (pending & ~pend_clr) | line_hit | sw_trig;

  // sticky until software writes a one
  always_ff @(posedge core_clk) begin
    if (sys_rst) pending <= EEL_RST_LINES;
    else pending <= next_pending;
  end

  // *****************************************
  // requests toward the core
  // *****************************************

  // per-line irq and the merged level, both held while pending
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_irq <= EEL_RST_LINES;
      irq <= 1'b0;
    end else begin
      line_irq <= pending & irq_mask;
      irq <= |(pending & irq_mask);
    end
  end

  // events are one-cycle pulses, never latched
  always_ff @(posedge core_clk) begin
    if (sys_rst) line_event <= EEL_RST_LINES;
    else line_event <= line_hit & evt_mask;
  end

  // clocked wake-up: pending irq or a fresh event
  always_ff @(posedge core_clk) begin
    if (sys_rst) wake_q <= 1'b0;
    else wake_q <= |(pending & irq_mask) | |(line_hit & evt_mask);
  end

  // with the clock stopped only the pin catchers can see anything
  assign stop_wake = |(ext_caught & (irq_mask[15:0] | evt_mask[15:0]));
  assign wake_req = wake_q | stop_wake;

  // *****************************************
  // read path
  // *****************************************

  // read mux; write-only and reserved bits read as zero
  always_comb begin
    read_word = 32'h00000000;
    case (paddr)
      EEL_OFS_RISE: read_word = {8'h00, rise_en};
      EEL_OFS_FALL: read_word = {8'h00, fall_en};
      EEL_OFS_IMASK: read_word = {8'h00, irq_mask};
      EEL_OFS_EMASK: read_word = {8'h00, evt_mask};
      EEL_OFS_PEND: read_word = {8'h00, pending};
      EEL_OFS_LEVEL: read_word = {8'h00, int_cur, ext_level};
      default: begin
        if (paddr >= EEL_OFS_SEL && addr_ok) begin
          read_word = {26'h0, pin_sel[eel_sel_idx(paddr)]};
        end
      end
    endcase
  end

  // data captured at setup and held through the access cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) prdata <= EEL_RST_RDATA;
    else if (rd_setup) prdata <= read_word;
  end

  // *****************************************
  // checks
  // *****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_pend_set: assert property (
    (|line_hit) |=> ((pending & $past(line_hit)) == $past(line_hit)))
    else $error("detected edge did not set pending");

  a_pend_hold: assert property (
    !(wr_acc && paddr == EEL_OFS_PEND)
      |=> ((pending & $past(pending)) == $past(pending)))
    else $error("pending bit fell without a clear write");

  a_pend_clear: assert property (
    (wr_acc && paddr == EEL_OFS_PEND && line_hit == 24'h000000)
      |=> ((pending & $past(pwdata[23:0])) == 24'h000000))
    else $error("write-one did not clear pending");

  a_irq_level: assert property (
    (|(pending & irq_mask)) |=> irq)
    else $error("irq low while unmasked pending set");

  a_evt_mask: assert property (
    (|line_hit) |=> (line_event == ($past(line_hit) & $past(evt_mask))))
    else $error("event output ignores its mask");

  a_mask_write: assert property (
    (wr_acc && paddr == EEL_OFS_IMASK) |=> (irq_mask == $past(pwdata[23:0])))
    else $error("irq mask write not taken");

  a_edge_quiet: assert property (
    ((int_cur ^ int_prev) == 8'h00) |-> (line_hit[23:16] == 8'h00))
    else $error("internal line hit without a transition");

  a_edge_rise: assert property (
    (|(int_cur & ~int_prev & rise_en[23:16])) |-> (|line_hit[23:16]))
    else $error("enabled rising edge missed");

  a_wake_req: assert property (
    (|(line_hit & (irq_mask | evt_mask))) |-> ##[1:2] wake_req)
    else $error("unmasked hit raised no wake-up");

  // the checks below pin down masking, software writes and the fall path
  a_swtrig_set: assert property (
    (wr_acc && paddr == EEL_OFS_SWTRIG)
      |=> ((pending & $past(pwdata[23:0])) == $past(pwdata[23:0])))
    else $error("software trigger did not set pending");

  a_irq_masked: assert property (
    ((pending & irq_mask) == 24'h000000) |=> !irq)
    else $error("irq high with every pending line masked");

  a_line_held: assert property (
    (|(pending & irq_mask))
      |=> ((line_irq & $past(pending & irq_mask)) == $past(pending & irq_mask)))
    else $error("line irq dropped while its pending bit stood");

  a_event_idle: assert property (
    (line_hit == 24'h000000) |=> (line_event == 24'h000000))
    else $error("event pulse without a detected edge");

  a_edge_fall: assert property (
    (|(~int_cur & int_prev & fall_en[23:16])) |-> (|line_hit[23:16]))
    else $error("enabled falling edge missed");

  a_sel_write: assert property (
    (wr_acc && paddr == EEL_OFS_SEL) |=> (pin_sel[0] == $past(pwdata[5:0])))
    else $error("pin selector write not taken");

endmodule // eel_ctrl

`default_nettype wire

// ===== eel_irq_sink.sv
// far-side model: vectored_irq_controller and wake-up logic, listen only
// assumes it shares core_clk and sys_rst with the line controller
`timescale 1ns/1ns
`default_nettype none

module eel_irq_sink
  import eel_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // requests from the line controller
  input wire logic [23:0] line_irq,
  input wire logic [23:0] line_event,
  input wire logic irq,
  input wire logic wake_req,
  // observations for the bench
  output logic [7:0] evt_count,
  output logic wake_seen
);
  // ****************************************
  // event pulses are one cycle wide, so count them every edge
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      evt_count <= 8'h00;
    end else begin
      evt_count <= evt_count + 8'($countones(line_event));
    end
  end
  // irq is a level held until software clears; it is never acked here
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_seen <= 1'b0;
    end else if (wake_req && irq) begin
      wake_seen <= 1'b1;
    end
  end
endmodule // eel_irq_sink

`default_nettype wire

// ===== eel_ctrl_tb.sv
// self-checking bench for the edge/event line controller
// assumes eel_pkg compiled first; drives apb, pads and internal sources
`timescale 1ns/1ns
`default_nettype none

module eel_ctrl_tb;
  import eel_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, wake_req, wake_seen;
  logic [54:0] gpio_pin = '0;
  logic [7:0] int_src = 8'h00;
  logic [23:0] line_irq, line_event;
  logic [7:0] evt_count;
  int n_mismatch = 0;
  int num_checks = 0;

  // ****************************************
  // clock, dut and far side
  // ****************************************
  always #5 core_clk = ~core_clk;
  eel_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_pin(gpio_pin), .supply_voltage_detector_out(int_src[0]),
    .rtc_alarm(int_src[1]), .rtc_tamper(int_src[2]), .i2c_wake(int_src[3]),
    .usart_wake(int_src[4]), .comparator1_out(int_src[5]), .comparator2_out(int_src[6]),
    .consumer_control_wake(int_src[7]), .line_irq(line_irq), .line_event(line_event),
    .irq(irq), .wake_req(wake_req));
  eel_irq_sink i_sink (.core_clk(core_clk), .sys_rst(sys_rst), .line_irq(line_irq),
    .line_event(line_event), .irq(irq), .wake_req(wake_req), .evt_count(evt_count),
    .wake_seen(wake_seen));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic clear_all();
    wr(EEL_OFS_PEND, 32'h00FFFFFF);
    idle(3);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd("rise_en", EEL_OFS_RISE, 32'h0);
    rd("irq_mask", EEL_OFS_IMASK, 32'h0);
    rd("pending", EEL_OFS_PEND, 32'h0);
    rd("sel0", EEL_OFS_SEL, 32'h0);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF, r, e);
    chk("slverr", {31'h0, e}, 32'h1);
    rd("swtrig", EEL_OFS_SWTRIG, 32'h0);
    // code 63 is past the last pad: line 3 goes quiet, only six bits stick
    wr(EEL_OFS_SEL + 8'h0C, 32'hFFFFFFFF);
    rd("sel3", EEL_OFS_SEL + 8'h0C, 32'h3F);
  endtask
  // pulse far shorter than a clock period must still be caught
  task automatic t_narrow();
    wr(EEL_OFS_SEL, 32'd5);
    wr(EEL_OFS_RISE, 32'h1);
    wr(EEL_OFS_IMASK, 32'h1);
    wr(EEL_OFS_EMASK, 32'h1);
    @(posedge core_clk);
    gpio_pin[5] <= 1'b1;
    #3;
    gpio_pin[5] <= 1'b0;
    #1;
    // no clock edge has seen the pulse yet, so only the catcher can wake
    chk("stop_wake", {31'h0, wake_req}, 32'h1);
    idle(20);
    rd("pend_narrow", EEL_OFS_PEND, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("line_irq", {8'h0, line_irq}, 32'h1);
    chk("wake", {31'h0, wake_seen}, 32'h1);
    chk("events", {24'h0, evt_count}, 32'h1);
    clear_all();
    chk("irq_clr", {31'h0, irq}, 32'h0);
  endtask
  // rise only, fall only, both; each edge checked separately
  task automatic t_modes();
    logic [1:0] m;
    wr(EEL_OFS_SEL + 8'h04, 32'd54);
    for (int k = 1; k <= 3; k++) begin
      m = 2'(k);
      wr(EEL_OFS_RISE, {30'h0, m[0], 1'b0});
      wr(EEL_OFS_FALL, {30'h0, m[1], 1'b0});
      gpio_pin[54] <= 1'b1;
      idle(12);
      rd("pend_rise", EEL_OFS_PEND, {30'h0, m[0], 1'b0});
      clear_all();
      gpio_pin[54] <= 1'b0;
      idle(12);
      rd("pend_fall", EEL_OFS_PEND, {30'h0, m[1], 1'b0});
      clear_all();
    end
    wr(EEL_OFS_FALL, 32'h0);
  endtask
  // masked line pends but stays quiet; other line unaffected
  task automatic t_mask();
    wr(EEL_OFS_SEL + 8'h08, 32'd9);
    wr(EEL_OFS_RISE, 32'h4);
    wr(EEL_OFS_IMASK, 32'h1);
    wr(EEL_OFS_EMASK, 32'h0);
    gpio_pin[9] <= 1'b1;
    idle(12);
    rd("pend_masked", EEL_OFS_PEND, 32'h4);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    chk("wake_masked", {31'h0, wake_req}, 32'h0);
    wr(EEL_OFS_SWTRIG, 32'h1);
    idle(4);
    chk("line_irq_sw", {8'h0, line_irq}, 32'h1);
    clear_all();
    chk("irq_off", {31'h0, irq}, 32'h0);
  endtask
  // internal sources map onto lines 16..23 in order
  task automatic t_internal();
    wr(EEL_OFS_RISE, 32'h00FF0000);
    wr(EEL_OFS_IMASK, 32'h00FF0000);
    for (int i = 0; i < 8; i++) begin
      int_src[i] <= 1'b1;
      idle(6);
      rd("pend_int", EEL_OFS_PEND, 32'h1 << (16 + i));
      chk("line_irq_int", {8'h0, line_irq}, 32'h1 << (16 + i));
      clear_all();
    end
    // falling edge on the first internal line
    wr(EEL_OFS_FALL, 32'h00010000);
    int_src[0] <= 1'b0;
    idle(6);
    rd("pend_int_fall", EEL_OFS_PEND, 32'h00010000);
    clear_all();
    // pad 0 high: lines 4 to 15 follow it, quiet line 3 stays low
    gpio_pin[0] <= 1'b1;
    idle(3);
    rd("levels", EEL_OFS_LEVEL, 32'h00FEFFF4);
  endtask

  // ****************************************
  // end of run
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    idle(4);
    sys_rst <= 1'b0;
    idle(2);
    t_reset();
    t_narrow();
    t_modes();
    t_mask();
    t_internal();
    final_report();
  end
endmodule // eel_ctrl_tb

`default_nettype wire
